/* ecu_pkg.sv */
package ecu_pkg;
    // Register bus shape
    localparam int REG_AW = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 64;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RESULT = 8'h04;
    localparam logic [7:0] REG_TGT_LO = 8'h08;
    localparam logic [7:0] REG_TGT_HI = 8'h0c;
    localparam logic [7:0] REG_STR_LO = 8'h10;
    localparam logic [7:0] REG_STR_HI = 8'h14;
    localparam logic [7:0] REG_MODE = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_FADDR_LO = 8'h20;
    localparam logic [7:0] REG_FADDR_HI = 8'h24;
    localparam logic [7:0] REG_FCODE = 8'h28;
    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int MODE_64_BIT = 0;
    localparam int MODE_CPL_LSB = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_GP_BIT = 2;
    localparam int STAT_PF_BIT = 3;
    localparam int STAT_FLAGS_LSB = 4;
    // Flag vector order {of, sf, zf, af, pf, cf}
    localparam int FLAGS_W = 6;
    localparam logic [5:0] FLAGS_ZF_ONLY = 6'h08;
    localparam logic [5:0] FLAGS_CLEAR = 6'h00;
    // Leaf selection and privilege
    localparam logic [31:0] LEAF_DEC = 32'h0000_0000;
    localparam logic [31:0] LEAF_INC = 32'h0000_0001;
    localparam logic [1:0] CPL_KERNEL = 2'h0;
    localparam logic [1:0] CPL_RESET = 2'h3;
    // Page geometry and address form
    localparam int PAGE_OFS_W = 12;
    localparam logic [32:0] PAGE_LAST = 33'h0_0000_0fff;
    localparam int VA_BITS = 48;
    // Page types of the metadata map
    localparam int PTYPE_W = 8;
    localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
    localparam logic [7:0] THREAD_CONTROL_PAGE_TYPE = 8'h02;
    localparam logic [7:0] STRUCTURE_PAGE_TYPE = 8'h03;
    localparam logic [7:0] TRIMMED_PAGE_TYPE = 8'h04;
    localparam logic [7:0] FIRST_SHADOW_STACK_PAGE_TYPE = 8'h05;
    localparam logic [7:0] LATER_SHADOW_STACK_PAGE_TYPE = 8'h06;
    // Result codes
    localparam logic [31:0] RESULT_OK = 32'h0000_0000;
    localparam logic [31:0] PAGE_CONFLICT_ERROR = 32'h0000_0001;
    localparam logic [31:0] INVALID_COUNTER_ERROR = 32'h0000_0002;
    // Page fault error code
    localparam int PFEC_W = 32;
    localparam logic [31:0] ENCLAVE_FAULT_CODE_BIT = 32'h0000_8000;
    // Counter location inside the control structure
    localparam logic [63:0] COUNTER_OFFSET = 64'h0000_0000_0000_0100;
    localparam logic [63:0] COUNTER_ONE = 64'h0000_0000_0000_0001;

    typedef enum logic [1:0] {
        MEM_LOOKUP,
        MEM_READ,
        MEM_WRITE
    } ecu_mem_cmd_type;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_LK_T,
        ST_LK_S,
        ST_EVAL,
        ST_RD,
        ST_WR,
        ST_FIX
    } ecu_state_type;

    typedef enum {
        OUT_NONE,
        OUT_GP,
        OUT_PF,
        OUT_OK,
        OUT_CONFLICT,
        OUT_UNDERFLOW
    } ecu_outcome_type;
endpackage

/* ecu_addr_if.sv */
`timescale 1ns/1ps
interface ecu_addr_if;
    logic mode64;
    logic [63:0] ds_base;
    logic [31:0] ds_limit;
    logic ds_unusable;
    logic [63:0] tgt_off;
    logic [63:0] str_off;
    logic [63:0] tgt_lin;
    logic [63:0] str_lin;
    logic seg_fault;

    modport user (output mode64, ds_base, ds_limit, ds_unusable, tgt_off,
        str_off, input tgt_lin, str_lin, seg_fault);
    modport chk (input mode64, ds_base, ds_limit, ds_unusable, tgt_off,
        str_off, output tgt_lin, str_lin, seg_fault);
endinterface

/* ecu_addr_check.sv */
`timescale 1ns/1ps
module ecu_addr_check (
    ecu_addr_if.chk a
);
    logic [32:0] tgt_end;
    logic [32:0] str_end;
    logic tgt_canon;
    logic str_canon;

    // Page end offsets for the segment limit test
    assign tgt_end = {1'b0, a.tgt_off[31:0]} + ecu_pkg::PAGE_LAST;
    assign str_end = {1'b0, a.str_off[31:0]} + ecu_pkg::PAGE_LAST;

    // Upper bits must all copy the top implemented bit
    assign tgt_canon = (&a.tgt_off[63:ecu_pkg::VA_BITS-1]) ||
        ~(|a.tgt_off[63:ecu_pkg::VA_BITS-1]);
    assign str_canon = (&a.str_off[63:ecu_pkg::VA_BITS-1]) ||
        ~(|a.str_off[63:ecu_pkg::VA_BITS-1]);

    // Data segment alone forms both addresses, no override path
    always_comb begin
        if (a.mode64) begin
            a.tgt_lin = a.tgt_off;
            a.str_lin = a.str_off;
            a.seg_fault = !tgt_canon || !str_canon;
        end else begin
            a.tgt_lin = {32'h0000_0000,
                a.ds_base[31:0] + a.tgt_off[31:0]};
            a.str_lin = {32'h0000_0000,
                a.ds_base[31:0] + a.str_off[31:0]};
            a.seg_fault = a.ds_unusable ||
                (tgt_end > {1'b0, a.ds_limit}) ||
                (str_end > {1'b0, a.ds_limit});
        end
    end
endmodule // ecu_addr_check

/* ecu_leaf_unit.sv */
// Behaviour
// - Leaf 01H increments the structure's virtual child counter.
// - Leaf 00H decrements the structure's virtual child counter.
// - Both operand addresses use the data segment; no override.
// - Third check, after privilege and leaf: unaligned target page gives protection fault zero.
// - Target or structure outside protected memory gives enclave page fault.
// - Target under concurrent change: zero flag, conflict code, skip on.
// - Then an invalid target metadata entry gives enclave page fault.
// - Parent from owner, or target itself if structure; else page fault.
// - Derived parent differing from structure operand gives protection fault.
// - Locked decrement; underflow restores counter, zero flag, error code.
// - Success clears zero flag and writes zero result.
// - Non-faulting outcomes clear carry, parity, aux, overflow, sign.
// - Counter and derived parent address are 64-bit values.
// - 32-bit mode: beyond segment limit or unusable segment faults.
// - 64-bit mode: non-canonical operand address faults.
// - Any access page fault is reported with its error code; faults on the counter writes are ignored.
// - Locked increment, no overflow check, zero flag and result cleared.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module ecu_leaf_unit (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [63:0] ds_base_in,
    input wire logic [31:0] ds_limit_in,
    input wire logic ds_unusable_in,
    output logic mem_req_out,
    output logic [1:0] mem_cmd_out,
    output logic [63:0] mem_addr_out,
    output logic [63:0] mem_wdata_out,
    output logic mem_lock_out,
    input wire logic mem_ack_in,
    input wire logic mem_fault_in,
    input wire logic [31:0] mem_pfec_in,
    input wire logic mem_resident_in,
    input wire logic mem_busy_in,
    input wire logic mem_valid_in,
    input wire logic [7:0] mem_type_in,
    input wire logic [63:0] mem_owner_in,
    input wire logic [63:0] mem_phys_in,
    input wire logic [63:0] mem_rdata_in,
    output logic done_out,
    output logic gp_fault_out,
    output logic pf_fault_out
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;
    ecu_pkg::ecu_state_type state_q;
    ecu_pkg::ecu_state_type state_d;
    ecu_pkg::ecu_outcome_type outcome;
    logic [31:0] leaf_q;
    logic [31:0] result_q;
    logic [63:0] tgt_off_q;
    logic [63:0] str_off_q;
    logic mode64_q;
    logic [1:0] cpl_q;
    logic start;
    logic [ecu_pkg::FLAGS_W-1:0] flags_q;
    logic done_q;
    logic gp_q;
    logic pf_q;
    logic [63:0] faddr_q;
    logic [31:0] fcode_q;
    logic [63:0] out_faddr;
    logic [31:0] out_fcode;
    logic [63:0] tgt_lin_q;
    logic [63:0] str_lin_q;
    logic t_res_q;
    logic t_busy_q;
    logic t_valid_q;
    logic [7:0] t_type_q;
    logic [63:0] t_owner_q;
    logic [63:0] t_phys_q;
    logic s_res_q;
    logic [63:0] s_phys_q;
    logic [63:0] parent_d;
    logic [63:0] parent_q;
    logic parent_ok;
    logic [63:0] cnt_old_q;
    logic [63:0] cnt_new_q;
    logic underflow_q;
    logic is_dec;
    logic [1:0] mem_cmd_q;
    logic [63:0] mem_addr_q;
    logic [63:0] mem_wdata_q;
    logic [31:0] rdata_q;
    logic done_p_q;
    logic gp_p_q;
    logic pf_p_q;

    ecu_addr_if ai ();

    // Reset release through two flops
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Address formation and segment checks
    assign ai.mode64 = mode64_q;
    assign ai.ds_base = ds_base_in;
    assign ai.ds_limit = ds_limit_in;
    assign ai.ds_unusable = ds_unusable_in;
    assign ai.tgt_off = tgt_off_q;
    assign ai.str_off = str_off_q;

    ecu_addr_check u_chk (
        .a(ai.chk)
    );

    assign is_dec = (leaf_q == ecu_pkg::LEAF_DEC);
    assign start = reg_wr_in && (reg_addr_in == ecu_pkg::REG_CTRL) &&
        reg_wdata_in[ecu_pkg::CTRL_START_BIT] && (state_q == ecu_pkg::ST_IDLE);

    // Parent derivation from the target metadata entry
    always_comb begin
        parent_d = t_owner_q;
        parent_ok = 1'b1;
        unique case (t_type_q)
            ecu_pkg::REGULAR_PAGE_TYPE,
            ecu_pkg::THREAD_CONTROL_PAGE_TYPE,
            ecu_pkg::TRIMMED_PAGE_TYPE,
            ecu_pkg::FIRST_SHADOW_STACK_PAGE_TYPE,
            ecu_pkg::LATER_SHADOW_STACK_PAGE_TYPE: begin
                parent_d = t_owner_q;
            end
            ecu_pkg::STRUCTURE_PAGE_TYPE: begin
                parent_d = t_phys_q;
            end
            default: begin
                parent_ok = 1'b0;
            end
        endcase
    end

    // Sequencing and ordered checks
    always_comb begin
        state_d = state_q;
        outcome = ecu_pkg::OUT_NONE;
        out_faddr = tgt_lin_q;
        out_fcode = ecu_pkg::ENCLAVE_FAULT_CODE_BIT;
        unique case (state_q)
            ecu_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = ecu_pkg::ST_ADDR;
                end
            end
            ecu_pkg::ST_ADDR: begin
                if (cpl_q != ecu_pkg::CPL_KERNEL) begin
                    outcome = ecu_pkg::OUT_GP;
                end else if (!is_dec && leaf_q != ecu_pkg::LEAF_INC) begin
                    outcome = ecu_pkg::OUT_GP;
                end else if (|tgt_off_q[ecu_pkg::PAGE_OFS_W-1:0]) begin
                    outcome = ecu_pkg::OUT_GP;
                end else if (|str_off_q[ecu_pkg::PAGE_OFS_W-1:0]) begin
                    outcome = ecu_pkg::OUT_GP;
                end else if (ai.seg_fault) begin
                    outcome = ecu_pkg::OUT_GP;
                end else begin
                    state_d = ecu_pkg::ST_LK_T;
                end
            end
            ecu_pkg::ST_LK_T, ecu_pkg::ST_LK_S, ecu_pkg::ST_RD: begin
                if (mem_ack_in && mem_fault_in) begin
                    outcome = ecu_pkg::OUT_PF;
                    out_faddr = mem_addr_q;
                    out_fcode = mem_pfec_in;
                end else if (mem_ack_in) begin
                    state_d = (state_q == ecu_pkg::ST_LK_T) ?
                        ecu_pkg::ST_LK_S : (state_q == ecu_pkg::ST_LK_S) ?
                        ecu_pkg::ST_EVAL : ecu_pkg::ST_WR;
                end
            end
            ecu_pkg::ST_EVAL: begin
                if (!t_res_q) begin
                    outcome = ecu_pkg::OUT_PF;
                end else if (!s_res_q) begin
                    outcome = ecu_pkg::OUT_PF;
                    out_faddr = str_lin_q;
                end else if (t_busy_q) begin
                    outcome = ecu_pkg::OUT_CONFLICT;
                end else if (!t_valid_q) begin
                    outcome = ecu_pkg::OUT_PF;
                end else if (!parent_ok) begin
                    outcome = ecu_pkg::OUT_PF;
                end else if (parent_d != s_phys_q) begin
                    outcome = ecu_pkg::OUT_GP;
                end else begin
                    state_d = ecu_pkg::ST_RD;
                end
            end
            ecu_pkg::ST_WR: begin
                if (mem_ack_in && underflow_q) begin
                    state_d = ecu_pkg::ST_FIX;
                end else if (mem_ack_in) begin
                    outcome = ecu_pkg::OUT_OK;
                end
            end
            ecu_pkg::ST_FIX: begin
                if (mem_ack_in) begin
                    outcome = ecu_pkg::OUT_UNDERFLOW;
                end
            end
        endcase
        if (outcome != ecu_pkg::OUT_NONE) begin
            state_d = ecu_pkg::ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ecu_pkg::ST_IDLE;
        end else if (ce_in) begin
            state_q <= state_d;
        end
    end

    // Captured lookup answers and counter arithmetic
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tgt_lin_q <= 64'h0;
            str_lin_q <= 64'h0;
            t_res_q <= 1'b0;
            t_busy_q <= 1'b0;
            t_valid_q <= 1'b0;
            t_type_q <= 8'h00;
            t_owner_q <= 64'h0;
            t_phys_q <= 64'h0;
            s_res_q <= 1'b0;
            s_phys_q <= 64'h0;
            parent_q <= 64'h0;
            cnt_old_q <= 64'h0;
            cnt_new_q <= 64'h0;
            underflow_q <= 1'b0;
        end else if (ce_in) begin
            if (state_q == ecu_pkg::ST_ADDR) begin
                tgt_lin_q <= ai.tgt_lin;
                str_lin_q <= ai.str_lin;
            end
            if (state_q == ecu_pkg::ST_LK_T && mem_ack_in) begin
                t_res_q <= mem_resident_in;
                t_busy_q <= mem_busy_in;
                t_valid_q <= mem_valid_in;
                t_type_q <= mem_type_in;
                t_owner_q <= mem_owner_in;
                t_phys_q <= mem_phys_in;
            end
            if (state_q == ecu_pkg::ST_LK_S && mem_ack_in) begin
                s_res_q <= mem_resident_in;
                s_phys_q <= mem_phys_in;
            end
            if (state_q == ecu_pkg::ST_EVAL) begin
                parent_q <= parent_d;
            end
            if (state_q == ecu_pkg::ST_RD && mem_ack_in) begin
                cnt_old_q <= mem_rdata_in;
                if (is_dec) begin
                    cnt_new_q <= mem_rdata_in - ecu_pkg::COUNTER_ONE;
                    underflow_q <= (mem_rdata_in == 64'h0);
                end else begin
                    cnt_new_q <= mem_rdata_in + ecu_pkg::COUNTER_ONE;
                    underflow_q <= 1'b0;
                end
            end
        end
    end

    // Memory port command, address and write data
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            mem_cmd_q <= ecu_pkg::MEM_LOOKUP;
            mem_addr_q <= 64'h0;
            mem_wdata_q <= 64'h0;
        end else if (ce_in) begin
            unique case (state_d)
                ecu_pkg::ST_LK_T: begin
                    mem_cmd_q <= ecu_pkg::MEM_LOOKUP;
                    mem_addr_q <= ai.tgt_lin;
                end
                ecu_pkg::ST_LK_S: begin
                    mem_cmd_q <= ecu_pkg::MEM_LOOKUP;
                    mem_addr_q <= str_lin_q;
                end
                ecu_pkg::ST_RD: begin
                    mem_cmd_q <= ecu_pkg::MEM_READ;
                    mem_addr_q <= parent_d + ecu_pkg::COUNTER_OFFSET;
                end
                ecu_pkg::ST_WR: begin
                    mem_cmd_q <= ecu_pkg::MEM_WRITE;
                    if (state_q == ecu_pkg::ST_RD) mem_wdata_q <= is_dec ?
                        mem_rdata_in - ecu_pkg::COUNTER_ONE :
                        mem_rdata_in + ecu_pkg::COUNTER_ONE;
                end
                ecu_pkg::ST_FIX: begin
                    mem_cmd_q <= ecu_pkg::MEM_WRITE;
                    mem_wdata_q <= cnt_old_q;
                end
                default: begin
                    mem_cmd_q <= mem_cmd_q;
                end
            endcase
        end
    end

    // Counter update held locked from read to last write
    assign mem_req_out = (state_q == ecu_pkg::ST_LK_T) ||
        (state_q == ecu_pkg::ST_LK_S) || mem_lock_out;
    assign mem_lock_out = (state_q == ecu_pkg::ST_RD) ||
        (state_q == ecu_pkg::ST_WR) ||
        (state_q == ecu_pkg::ST_FIX);
    assign mem_cmd_out = mem_cmd_q;
    assign mem_addr_out = mem_addr_q;
    assign mem_wdata_out = mem_wdata_q;

    // Software registers: operands, mode and leaf select
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tgt_off_q <= 64'h0;
            str_off_q <= 64'h0;
            mode64_q <= 1'b0;
            cpl_q <= ecu_pkg::CPL_RESET;
            leaf_q <= ecu_pkg::LEAF_DEC;
        end else if (ce_in && reg_wr_in && state_q == ecu_pkg::ST_IDLE) begin
            unique case (reg_addr_in)
                ecu_pkg::REG_TGT_LO: tgt_off_q[31:0] <= reg_wdata_in;
                ecu_pkg::REG_TGT_HI: tgt_off_q[63:32] <= reg_wdata_in;
                ecu_pkg::REG_STR_LO: str_off_q[31:0] <= reg_wdata_in;
                ecu_pkg::REG_STR_HI: str_off_q[63:32] <= reg_wdata_in;
                ecu_pkg::REG_RESULT: leaf_q <= reg_wdata_in;
                ecu_pkg::REG_MODE: begin
                    mode64_q <= reg_wdata_in[ecu_pkg::MODE_64_BIT];
                    cpl_q <= reg_wdata_in[ecu_pkg::MODE_CPL_LSB +: 2];
                end
                default: begin
                    cpl_q <= cpl_q;
                end
            endcase
        end
    end

    // Result, flags and fault report
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= ecu_pkg::RESULT_OK;
            flags_q <= ecu_pkg::FLAGS_CLEAR;
            done_q <= 1'b0;
            gp_q <= 1'b0;
            pf_q <= 1'b0;
            faddr_q <= 64'h0;
            fcode_q <= 32'h0;
        end else if (ce_in) begin
            if (start) begin
                done_q <= 1'b0;
                gp_q <= 1'b0;
                pf_q <= 1'b0;
            end
            unique case (outcome)
                ecu_pkg::OUT_OK: begin
                    result_q <= ecu_pkg::RESULT_OK;
                    flags_q <= ecu_pkg::FLAGS_CLEAR;
                end
                ecu_pkg::OUT_CONFLICT: begin
                    result_q <= ecu_pkg::PAGE_CONFLICT_ERROR;
                    flags_q <= ecu_pkg::FLAGS_ZF_ONLY;
                end
                ecu_pkg::OUT_UNDERFLOW: begin
                    result_q <= ecu_pkg::INVALID_COUNTER_ERROR;
                    flags_q <= ecu_pkg::FLAGS_ZF_ONLY;
                end
                ecu_pkg::OUT_GP: begin
                    gp_q <= 1'b1;
                    fcode_q <= 32'h0;
                end
                ecu_pkg::OUT_PF: begin
                    pf_q <= 1'b1;
                    faddr_q <= out_faddr;
                    fcode_q <= out_fcode;
                end
                default: begin
                    result_q <= result_q;
                end
            endcase
            if (outcome != ecu_pkg::OUT_NONE) begin
                done_q <= 1'b1;
            end
        end
    end

    // Completion and fault pulses
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            done_p_q <= 1'b0;
            gp_p_q <= 1'b0;
            pf_p_q <= 1'b0;
        end else if (ce_in) begin
            done_p_q <= (outcome != ecu_pkg::OUT_NONE);
            gp_p_q <= (outcome == ecu_pkg::OUT_GP);
            pf_p_q <= (outcome == ecu_pkg::OUT_PF);
        end else begin
            done_p_q <= 1'b0;
            gp_p_q <= 1'b0;
            pf_p_q <= 1'b0;
        end
    end
    assign done_out = done_p_q;
    assign gp_fault_out = gp_p_q;
    assign pf_fault_out = pf_p_q;

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
        end else if (ce_in && reg_rd_in) begin
            unique case (reg_addr_in)
                ecu_pkg::REG_RESULT: rdata_q <= result_q;
                ecu_pkg::REG_TGT_LO: rdata_q <= tgt_off_q[31:0];
                ecu_pkg::REG_TGT_HI: rdata_q <= tgt_off_q[63:32];
                ecu_pkg::REG_STR_LO: rdata_q <= str_off_q[31:0];
                ecu_pkg::REG_STR_HI: rdata_q <= str_off_q[63:32];
                ecu_pkg::REG_MODE: rdata_q <= {29'h0, cpl_q, mode64_q};
                ecu_pkg::REG_STATUS: rdata_q <= {22'h0, flags_q, pf_q, gp_q,
                    done_q, (state_q != ecu_pkg::ST_IDLE)};
                ecu_pkg::REG_FADDR_LO: rdata_q <= faddr_q[31:0];
                ecu_pkg::REG_FADDR_HI: rdata_q <= faddr_q[63:32];
                ecu_pkg::REG_FCODE: rdata_q <= fcode_q;
                default: rdata_q <= 32'h0;
            endcase
        end
    end
    assign reg_rdata_out = rdata_q;
endmodule // ecu_leaf_unit

/* ecu_leaf_unit_checker.sv */
`timescale 1ns/1ps
module ecu_leaf_unit_checker (
    input wire logic clk_sys_in, nrst_in, done_out, gp_fault_out, pf_fault_out,
    input wire logic mem_req_out, mem_ack_in, mem_fault_in, mem_lock_out,
    input wire logic [1:0] mem_cmd_out,
    input wire logic [63:0] mem_addr_out, mem_wdata_out, mem_rdata_in
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // Answered counter reads and writes
    wire ack = mem_req_out && mem_ack_in;
    wire rd_ack = ack && mem_cmd_out == 2'h1;
    wire wr_ack = ack && mem_cmd_out == 2'h2;
    sequence wr_s;
        mem_req_out && mem_lock_out && mem_cmd_out == 2'h2;
    endsequence
    hold_req_a: assert property (mem_req_out && !mem_ack_in |=>
        $stable(mem_addr_out)) else $error("address moved");
    lock_wr_a: assert property (rd_ack && !mem_fault_in |=> wr_s)
        else $error("no locked write");
    wr_value_a: assert property (wr_s ##0 $past(rd_ack) |->
        mem_wdata_out == $past(mem_rdata_in) + 64'h1 ||
        mem_wdata_out == $past(mem_rdata_in) - 64'h1) else $error("bad count");
    restore_a: assert property (wr_ack && &mem_wdata_out |=>
        wr_s ##0 mem_wdata_out == 64'h0) else $error("no restore");
    ok_done_a: assert property (wr_ack && ~&mem_wdata_out |=>
        done_out && !gp_fault_out && !pf_fault_out) else $error("no done");
    acc_pf_a: assert property (ack && mem_fault_in |->
        ##[1:2] done_out && pf_fault_out) else $error("no page fault");
    one_fault_a: assert property (gp_fault_out || pf_fault_out |->
        done_out && !(gp_fault_out && pf_fault_out)) else $error("bad fault");
    lock_cmd_a: assert property (mem_req_out && mem_lock_out |->
        mem_cmd_out != 2'h0) else $error("locked lookup");
endmodule // ecu_leaf_unit_checker
bind ecu_leaf_unit ecu_leaf_unit_checker chk (.*);

/* ecu_mem_model.sv */
`timescale 1ns/1ps
module ecu_mem_model (
    input wire logic clk_sys_in, mem_req_out,
    input wire logic [1:0] mem_cmd_out,
    input wire logic [63:0] mem_addr_out, mem_wdata_out,
    output logic mem_ack_in, mem_fault_in, mem_resident_in, mem_busy_in,
    output logic mem_valid_in,
    output logic [7:0] mem_type_in,
    output logic [31:0] mem_pfec_in,
    output logic [63:0] mem_owner_in, mem_phys_in, mem_rdata_in
);
    logic [63:0] cnt = 0, owner = 0, bad = '1;
    logic busy = 0, valid = 1, fault_rd = 0;
    logic [7:0] ptype = 8'h01;
    wire n = !mem_ack_in;
    // Answer after one or more cycles; an answered write stores the counter
    always @(posedge clk_sys_in) begin
        mem_ack_in <= mem_req_out && n && $urandom_range(1);
        if (mem_req_out && !n && mem_cmd_out == 2'h2) cnt <= mem_wdata_out;
    end
    // Fields invert outside the answered cycle; identity mapping
    assign {mem_resident_in, mem_busy_in, mem_valid_in, mem_type_in} =
        {mem_addr_out != bad, busy, valid, ptype} ^ {11{n}};
    assign {mem_owner_in, mem_phys_in, mem_rdata_in} =
        {owner, mem_addr_out, cnt} ^ {192{n}};
    assign mem_fault_in = fault_rd && !n && mem_cmd_out == 2'h1;
    assign mem_pfec_in = 32'h7;
endmodule // ecu_mem_model

/* enclave_child_counter_update_test.sv */
`timescale 1ns/1ps
module enclave_child_counter_update_test;
    logic clk_sys_in = 0, nrst_in = 0, ce_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic ds_unusable_in = 0, pend = 0, mem_req_out, mem_lock_out, mem_ack_in;
    logic mem_fault_in, mem_resident_in, mem_busy_in, mem_valid_in, done_out;
    logic gp_fault_out, pf_fault_out;
    logic [1:0] mem_cmd_out;
    logic [7:0] reg_addr_in = 0, mem_type_in;
    logic [31:0] reg_wdata_in = 0, ds_limit_in = '1, reg_rdata_out, mem_pfec_in;
    logic [63:0] ds_base_in = 0, mem_addr_out, mem_wdata_out, mem_owner_in;
    logic [63:0] mem_phys_in, mem_rdata_in, note, note_q[$];
    int errors = 0, n_checks = 0;
    localparam logic [63:0] S = 64'h1_0000, T = 64'h2_0000;
    localparam logic [31:0] ST[5] = '{32'h2, 32'h82, 32'h82, 32'h6, 32'ha};
    ecu_leaf_unit uut (.*);
    ecu_mem_model mdl (.*);
    initial forever #2 clk_sys_in = ~clk_sys_in;
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= d;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        bus(0, 1, a, 0);
        note_q.push_back({m, e & m});
    endtask
    // Read data stand in the cycle after the strobe
    always @(negedge clk_sys_in) begin
        if (pend) begin
            note = note_q.pop_front();
            chk("rdata", note[31:0], reg_rdata_out & note[63:32]);
        end
        pend = reg_rd_in;
    end
    // Kind 0 ok, 1 conflict, 2 underflow, 3 protection, 4 page fault
    task automatic run(logic lf, logic [63:0] t, logic [31:0] md, int k,
        logic [63:0] b = 0, logic [31:0] fc = ecu_pkg::ENCLAVE_FAULT_CODE_BIT);
        logic [63:0] c = mdl.cnt, s = S - b;
        logic [31:0] v[7] = '{lf, t[31:0], t[63:32], s[31:0], s[63:32], md, 1};
        for (int i = 0; i < 7; i++) bus(1, 0, i < 6 ? 8'(4 * i + 4) : 0, v[i]);
        bus(0, 0, 0, 0);
        for (int i = 0; i < 300 && done_out !== 1'b1; i++) @(negedge clk_sys_in);
        rd(ecu_pkg::REG_STATUS, ST[k], k > 2 ? 32'hf : 32'h3ff);
        rd(k < 3 ? ecu_pkg::REG_RESULT : ecu_pkg::REG_FCODE,
            k < 3 ? 32'(k) : k == 4 ? fc : 0, '1);
        bus(0, 0, 0, 0);
        chk("counter", k ? c : lf ? c + 1 : c - 1, mdl.cnt);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        final_report;
    end
    // Main sequence; leaves issued at privilege zero unless refused on purpose
    initial begin
        void'($urandom(13615));
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1;
        repeat (3) @(posedge clk_sys_in);
        mdl.owner = S;
        for (int p = 1; p < 8; p++) begin
            mdl.ptype = 8'(p);
            mdl.cnt = $urandom_range(200, 1);
            run(1, T, 1, p == 7 ? 4 : p == 3 ? 3 : 0);
        end
        mdl.ptype = 8'h03;
        run(1, S, 1, 0);
        mdl.ptype = 8'h01;
        run(0, T, 1, 0);
        mdl.cnt = 0;
        run(0, T, 1, 2);
        mdl.cnt = '1;
        run(1, T, 1, 0);
        mdl.busy = 1;
        mdl.valid = 0;
        run(1, T + 64'h8, 1, 3);
        run(1, T, 1, 1);
        mdl.busy = 0;
        run(1, T, 1, 4);
        mdl.valid = 1;
        mdl.bad = T;
        run(0, T, 1, 4);
        mdl.bad = S;
        run(0, T, 1, 4);
        mdl.bad = '1;
        run(1, T, 7, 3);
        run(1, T | 64'h1 << 48, 1, 3);
        ds_base_in <= 64'h1000;
        run(1, T - 64'h1000, 0, 0, 64'h1000);
        ds_limit_in <= 32'h100;
        run(1, T - 64'h1000, 0, 3, 64'h1000);
        ds_limit_in <= '1;
        ds_unusable_in <= 1;
        run(1, T - 64'h1000, 0, 3, 64'h1000);
        ds_unusable_in <= 0;
        mdl.fault_rd = 1;
        run(0, T, 1, 4, 0, 32'h7);
        repeat (3) @(posedge clk_sys_in);
        final_report;
    end
endmodule // enclave_child_counter_update_test
